// >>> logic/event_irq_and_sample_checker.sv
// Purpose: Event flags with open-drain interrupt, plus input sample checker
// Assumes: Register port is the internal side of the serial port engine
// Notes:   Reads answer one cycle after the strobe; ce low freezes all state, but rst and soft_rst still clear it
`default_nettype none
module event_irq_and_sample_checker (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        soft_rst,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   output logic             reg_rvalid,
   // Event sources
   input  wire logic [7:0]  event_src_a,
   input  wire logic [7:0]  event_src_b,
   output logic      [7:0]  sticky_clr_a,
   output logic      [7:0]  sticky_clr_b,
   // Sample input
   input  wire logic [13:0] sample_data,
   input  wire logic        sample_valid,
   input  wire logic        frame,
   // Interrupt pin
   output logic             irq_n_out,
   output logic             irq_n_oe
);

   typedef struct packed {
      logic [7:0]      en_a;
      logic [7:0]      en_b;
      logic [7:0]      lat_a;
      logic [7:0]      lat_b;
      logic [7:0]      prev_a;
      logic [7:0]      prev_b;
      logic            chk_en;
      logic            chk_auto;
      logic            err;
      logic            fail;
      logic            pass;
      logic [7:0][7:0] refs;
      logic [15:0]     log_i;
      logic [15:0]     log_q;
      logic [1:0]      idx;
      logic            frame_prev;
      logic            set_bad;
      logic [3:0]      clean_cnt;
      logic [7:0]      rdata;
      logic            rvalid;
      logic            irq_oe;
      logic [7:0]      sclr_a;
      logic [7:0]      sclr_b;
   } state_s;

   state_s q;
   state_s d;

   logic [7:0]  src_a;
   logic [7:0]  src_b;
   logic [7:0]  clr_a;
   logic [7:0]  clr_b;
   logic [7:0]  ctl_wr;
   logic [1:0]  use_idx;
   logic [15:0] ref_word;
   logic [15:0] diff;
   logic        mism;
   logic        bad;

   assign reg_rdata    = q.rdata;
   assign reg_rvalid   = q.rvalid;
   assign sticky_clr_a = q.sclr_a;
   assign sticky_clr_b = q.sclr_b;
   // Never drives high; pull-up is off chip
   assign irq_n_out    = 1'b0;
   assign irq_n_oe     = q.irq_oe;

   always_comb begin
      d        = q;
      d.rvalid = 1'b0;
      d.sclr_a = event_irq_pkg::RESET_BYTE;
      d.sclr_b = event_irq_pkg::RESET_BYTE;
      diff     = 16'h0000;
      mism     = 1'b0;
      bad      = 1'b0;
      use_idx  = q.idx;
      // Checker flags are the low sources of the second flag register
      src_a = event_src_a;
      src_b = {event_src_b[7:3], q.err, q.fail, q.pass};
      clr_a = event_irq_pkg::RESET_BYTE;
      clr_b = event_irq_pkg::RESET_BYTE;
      ctl_wr = event_irq_pkg::RESET_BYTE;

      if (reg_wr) begin
         unique case (reg_addr)
            event_irq_pkg::OFS_EN_A:    d.en_a = reg_wdata;
            event_irq_pkg::OFS_EN_B:    d.en_b = reg_wdata;
            event_irq_pkg::OFS_FLAG_A:  clr_a = reg_wdata;
            event_irq_pkg::OFS_FLAG_B:  clr_b = reg_wdata;
            event_irq_pkg::OFS_CHK_CTL: begin
               ctl_wr     = reg_wdata;
               d.chk_en   = reg_wdata[event_irq_pkg::CTL_ENABLE];
               d.chk_auto = reg_wdata[event_irq_pkg::CTL_AUTO];
            end
            default: begin
               if (reg_addr >= event_irq_pkg::OFS_REF_BASE &&
                   reg_addr <= event_irq_pkg::OFS_REF_LAST) begin
                  d.refs[reg_addr[2:0]] = reg_wdata;
               end
            end
         endcase
      end

      // Sticky sources outside are cleared with the flag write
      d.sclr_a = clr_a;
      d.sclr_b = clr_b;

      // Set wins over clear so no edge is lost
      d.prev_a = src_a;
      d.prev_b = src_b;
      d.lat_a  = (q.lat_a & ~clr_a) | (src_a & ~q.prev_a & q.en_a);
      d.lat_b  = (q.lat_b & ~clr_b) | (src_b & ~q.prev_b & q.en_b);

      // Only enabled latched flags reach the pin
      d.irq_oe = |(q.lat_a & q.en_a) | |(q.lat_b & q.en_b);

      // Software clears of checker status; new events below override
      if (ctl_wr[event_irq_pkg::CTL_ERR] || clr_b[event_irq_pkg::EVB_ERR]) begin
         d.err   = 1'b0;
         d.log_i = 16'h0000;
         d.log_q = 16'h0000;
      end
      if (ctl_wr[event_irq_pkg::CTL_FAIL] ||
          clr_b[event_irq_pkg::EVB_FAIL]) begin
         d.fail = 1'b0;
      end
      if (ctl_wr[event_irq_pkg::CTL_PASS] ||
          clr_b[event_irq_pkg::EVB_PASS]) begin
         d.pass = 1'b0;
      end

      // Rising frame marks I0; repeated marks on I0 and Q0 stay aligned
      if (sample_valid) begin
         d.frame_prev = frame;
         if (frame && !q.frame_prev) begin
            use_idx = 2'h0;
         end
      end
      ref_word = {q.refs[{use_idx, 1'b1}], q.refs[{use_idx, 1'b0}]};
      diff = {2'b00, sample_data ^ ref_word[event_irq_pkg::SAMPLE_W-1:0]};
      mism = |diff;

      if (q.chk_en && sample_valid) begin
         d.idx = use_idx + 2'h1;
         if (use_idx[0]) begin
            d.log_q = d.log_q | diff;
         end else begin
            d.log_i = d.log_i | diff;
         end
         d.set_bad = (use_idx == 2'h0) ? mism : (q.set_bad | mism);
         if (mism) begin
            d.err = 1'b1;
         end
         if (use_idx == event_irq_pkg::LAST_WORD) begin
            bad       = q.set_bad | mism;
            d.set_bad = 1'b0;
            if (q.chk_auto) begin
               d.pass = ~bad;
               if (bad) begin
                  d.fail      = 1'b1;
                  d.clean_cnt = 4'h0;
               end else if (q.clean_cnt == event_irq_pkg::CLEAN_SETS - 4'h1)
               begin
                  d.fail      = 1'b0;
                  d.log_i     = 16'h0000;
                  d.log_q     = 16'h0000;
                  d.clean_cnt = 4'h0;
               end else begin
                  d.clean_cnt = q.clean_cnt + 4'h1;
               end
            end
         end
      end

      // Pass and fail mean nothing outside auto-clear mode
      if (!d.chk_auto) begin
         d.pass      = 1'b0;
         d.fail      = 1'b0;
         d.clean_cnt = 4'h0;
      end

      if (reg_rd) begin
         d.rvalid = 1'b1;
         unique case (reg_addr)
            event_irq_pkg::OFS_EN_A:   d.rdata = q.en_a;
            event_irq_pkg::OFS_EN_B:   d.rdata = q.en_b;
            event_irq_pkg::OFS_FLAG_A: d.rdata = (q.lat_a & q.en_a) |
                                                 (src_a & ~q.en_a);
            event_irq_pkg::OFS_FLAG_B: d.rdata = (q.lat_b & q.en_b) |
                                                 (src_b & ~q.en_b);
            event_irq_pkg::OFS_CHK_CTL:
               d.rdata = {q.chk_en, q.chk_auto, q.err, 3'h0, q.fail, q.pass};
            event_irq_pkg::OFS_LOG_0:  d.rdata = q.log_i[7:0];
            event_irq_pkg::OFS_LOG_1:  d.rdata = q.log_i[15:8];
            event_irq_pkg::OFS_LOG_2:  d.rdata = q.log_q[7:0];
            event_irq_pkg::OFS_LOG_3:  d.rdata = q.log_q[15:8];
            default: begin
               if (reg_addr >= event_irq_pkg::OFS_REF_BASE &&
                   reg_addr <= event_irq_pkg::OFS_REF_LAST) begin
                  d.rdata = q.refs[reg_addr[2:0]];
               end else begin
                  d.rdata = event_irq_pkg::RESET_BYTE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst || soft_rst) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst || soft_rst);

   // Reset edge is excluded: past state there is the pre-reset state
   a_irq_from_flags: assert property (
      ce && $past(ce) && !$past(rst || soft_rst) |-> irq_n_oe ==
         (|($past(q.lat_a) & $past(q.en_a)) | |($past(q.lat_b) & $past(q.en_b))))
      else $error("interrupt enable does not match enabled flags");

   a_disabled_quiet: assert property (
      ce && q.en_a == 8'h00 && q.en_b == 8'h00 ##1 ce && $stable(q.en_a)
         && $stable(q.en_b) |-> !irq_n_oe)
      else $error("interrupt raised with all enables low");

   a_latch_on_rise: assert property (
      ce && q.en_a[0] && event_src_a[0] && !q.prev_a[0] |=> q.lat_a[0])
      else $error("enabled flag did not latch on rising edge");

   a_w1c_clears: assert property (
      ce && reg_wr && reg_addr == event_irq_pkg::OFS_FLAG_A && reg_wdata[0]
         && !(event_src_a[0] && !q.prev_a[0]) |=> !q.lat_a[0])
      else $error("write one did not clear latched flag");

   a_err_sticky: assert property (
      ce && q.err && !(reg_wr && (reg_addr == event_irq_pkg::OFS_CHK_CTL ||
         reg_addr == event_irq_pkg::OFS_FLAG_B)) |=> q.err)
      else $error("sample error flag dropped without a clear");

   a_mismatch_sets: assert property (
      ce && q.chk_en && sample_valid && mism |=> q.err)
      else $error("mismatch not recorded");

   a_pass_fail_mode: assert property (
      !q.chk_auto |-> !q.pass && !q.fail)
      else $error("pass or fail set outside auto-clear mode");

   a_fail_clears: assert property (
      ce && q.chk_auto && q.chk_en && sample_valid && !reg_wr
         && use_idx == 2'h3 && !bad && q.clean_cnt == 4'h7 |=> !q.fail
         && q.log_i == 16'h0000 && q.log_q == 16'h0000)
      else $error("eighth clean set did not clear fail and logs");

   a_read_answer: assert property (
      ce && reg_rd |=> reg_rvalid)
      else $error("read not answered next cycle");

   a_rvalid_pulse: assert property (
      ce && !reg_rd |=> !reg_rvalid)
      else $error("read answer without a read strobe");

   a_no_latch_off: assert property (
      ce && !q.en_a[0] && !q.lat_a[0] |=> !q.lat_a[0])
      else $error("disabled flag latched");

   a_flag_read_live: assert property (
      ce && reg_rd && reg_addr == event_irq_pkg::OFS_FLAG_A
         && q.en_a == 8'h00 |=> reg_rdata == $past(event_src_a))
      else $error("disabled flag read is not the live source");

   // Sticky sources outside rely on this one-cycle copy of the write
   a_sticky_a: assert property (
      ce && reg_wr && reg_addr == event_irq_pkg::OFS_FLAG_A
         |=> sticky_clr_a == $past(reg_wdata))
      else $error("sticky clear a does not follow flag write");

   a_sticky_b: assert property (
      ce && reg_wr && reg_addr == event_irq_pkg::OFS_FLAG_B
         |=> sticky_clr_b == $past(reg_wdata))
      else $error("sticky clear b does not follow flag write");

   a_ref_store: assert property (
      ce && reg_wr && reg_addr == event_irq_pkg::OFS_REF_BASE
         |=> q.refs[0] == $past(reg_wdata))
      else $error("reference byte not stored");

   // Logs may only grow unless cleared or auto-cleared
   a_log_accum: assert property (
      ce && q.chk_en && sample_valid && !reg_wr
         && !(q.chk_auto && use_idx == event_irq_pkg::LAST_WORD)
         |=> ((q.log_i | $past(q.log_i)) == q.log_i)
         && ((q.log_q | $past(q.log_q)) == q.log_q))
      else $error("error log lost a bit without a clear");

   a_pass_result: assert property (
      ce && q.chk_en && q.chk_auto && sample_valid && !reg_wr
         && use_idx == event_irq_pkg::LAST_WORD |=> q.pass == !$past(bad))
      else $error("pass bit does not match the set result");

   a_fail_on_bad: assert property (
      ce && q.chk_en && q.chk_auto && sample_valid && !reg_wr
         && use_idx == event_irq_pkg::LAST_WORD && bad |=> q.fail)
      else $error("fail bit not set on a bad set");

   // Checker error reaches flag b like any other event source
   a_err_latches: assert property (
      ce && q.en_b[event_irq_pkg::EVB_ERR] && q.err
         && !q.prev_b[event_irq_pkg::EVB_ERR] |=> q.lat_b[event_irq_pkg::EVB_ERR])
      else $error("enabled sample error did not latch");

   a_clean_bound: assert property (
      q.clean_cnt < event_irq_pkg::CLEAN_SETS)
      else $error("clean set count out of range");

   c_irq_asserted: cover property (ce && irq_n_oe);
   c_fail_then_clear: cover property (q.fail ##[1:200] !q.fail);
   c_mismatch_seen: cover property (ce && q.chk_en && sample_valid && mism);
   c_pass_seen: cover property (ce && q.pass);
   c_sticky_pulse: cover property (ce && sticky_clr_b != 8'h00);

endmodule
`default_nettype wire

// >>> logic/event_irq_pkg.sv
// Purpose: Constants for the event flag, interrupt and sample checker block
// Assumes: Byte-wide register port from the serial port engine
// Notes:   Behaviour
// Behaviour
// - Interrupt line is active low, open drain, shareable as wired-OR.
// - Two flag registers, each flag with its own enable bit.
// - Enabled flag latches on source rising edge and asserts interrupt.
// - Disabled flag shows live source and never drives the interrupt.
// - Writing one to a latched flag bit clears it.
// - Hardware or software reset clears every latched flag.
// - Writing a flag bit also clears its sticky source.
// - Checker compares input samples to loaded references, records mismatch.
// - Set of four 14-bit words: I0, Q0, I1, Q1.
// - Bit 5 of checker control is sticky sample error until cleared.
// - Four log registers latch every mismatching bit until cleared.
// - Fail bit 1 and pass bit 0 work only in auto-clear mode.
// - Auto-clear: pass on clean comparison, fail on mismatch.
// - Auto-clear: fail clears after eight consecutive clean comparisons.
// - Auto-clear: logs still accumulate, zeroed after eight clean ones.
// - Sample error, pass and fail can each raise the interrupt.
// - References are eight bytes: low and high of I0, Q0, I1, Q1.
package event_irq_pkg;
   localparam logic [7:0] OFS_EN_A     = 8'h04;
   localparam logic [7:0] OFS_EN_B     = 8'h05;
   localparam logic [7:0] OFS_FLAG_A   = 8'h06;
   localparam logic [7:0] OFS_FLAG_B   = 8'h07;
   localparam logic [7:0] OFS_CHK_CTL  = 8'h67;
   localparam logic [7:0] OFS_REF_BASE = 8'h68;
   localparam logic [7:0] OFS_REF_LAST = 8'h6f;
   localparam logic [7:0] OFS_LOG_0    = 8'h70;
   localparam logic [7:0] OFS_LOG_1    = 8'h71;
   localparam logic [7:0] OFS_LOG_2    = 8'h72;
   localparam logic [7:0] OFS_LOG_3    = 8'h73;

   localparam int CTL_ENABLE = 7;
   localparam int CTL_AUTO   = 6;
   localparam int CTL_ERR    = 5;
   localparam int CTL_FAIL   = 1;
   localparam int CTL_PASS   = 0;

   localparam int EVB_ERR  = 2;
   localparam int EVB_FAIL = 1;
   localparam int EVB_PASS = 0;

   localparam int          SAMPLE_W   = 14;
   localparam logic [1:0]  LAST_WORD  = 2'h3;
   localparam logic [3:0]  CLEAN_SETS = 4'h8;
   localparam logic [7:0]  RESET_BYTE = 8'h00;
endpackage

// >>> tb/sample_source.sv
// Purpose: Input data source sending I0,Q0,I1,Q1 sets with a frame marker
// Assumes: Runs while run is high, one word per clock
// Notes:   inj corrupts bits 13 and 0 of I0 words
`default_nettype none
module sample_source (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              rst,
   // Control
   input  wire logic              run,
   input  wire logic              inj,
   input  wire logic [3:0][13:0]  ref_w,
   // Sample output
   output logic      [13:0]       sample_data,
   output logic                   sample_valid,
   output logic                   frame
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] idx_q;
   always_ff @(posedge clock) begin
      if (rst) begin
         idx_q        <= 2'h0;
         sample_valid <= 1'b0;
         frame        <= 1'b0;
         sample_data  <= 14'h0000;
      end else if (!run) begin
         idx_q        <= 2'h0;
         sample_valid <= 1'b0;
         frame        <= 1'b0;
         // Idle bus never keeps the last word
         sample_data  <= ~sample_data;
      end else begin
         sample_valid <= 1'b1;
         frame        <= (idx_q == 2'h0);
         sample_data  <= ref_w[idx_q]
            ^ ((inj && idx_q == 2'h0) ? 14'h2001 : 14'h0000);
         idx_q        <= idx_q + 2'h1;
      end
   end
endmodule
`default_nettype wire

// >>> tb/event_irq_and_sample_checker_tb.sv
// Purpose: Self-checking bench for event flags, interrupt and checker
// Assumes: Register reads answer exactly one cycle after the strobe
// Notes:   ce and event_src_b stay fixed
`default_nettype none
module event_irq_and_sample_checker_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic             clock, rst, ce, soft_rst, reg_wr, reg_rd, reg_rvalid;
   logic [7:0]       reg_addr, reg_wdata, reg_rdata, src_a, clr_a, clr_b;
   logic [13:0]      sample_data;
   logic             sample_valid, frame, irq_n_out, irq_n_oe, run, inj;
   logic [3:0][13:0] ref_w;
   int               error_cnt, comparisons;
   // Wire is pulled up unless the block pulls it low
   wire              irq_line = irq_n_oe ? irq_n_out : 1'b1;
   event_irq_and_sample_checker dut_u (
      .clock(clock), .rst(rst), .ce(ce), .soft_rst(soft_rst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .event_src_a(src_a), .event_src_b(8'h00),
      .sticky_clr_a(clr_a), .sticky_clr_b(clr_b),
      .sample_data(sample_data), .sample_valid(sample_valid),
      .frame(frame), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
   sample_source src_u (
      .clock(clock), .rst(rst), .run(run), .inj(inj), .ref_w(ref_w),
      .sample_data(sample_data), .sample_valid(sample_valid),
      .frame(frame));
   task automatic close_out();
      if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clock);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, e);
      @(posedge clock);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      chk("rvalid", 8'h01, {7'h00, reg_rvalid});
      chk($sformatf("reg %h", a), e, reg_rdata);
   endtask
   task automatic irq(input logic e);
      #1 chk("irq", {7'h00, e}, {7'h00, irq_line});
   endtask
   task automatic t_reset();
      rd(8'h04, 8'h00);
      rd(8'h67, 8'h00);
      rd(8'h50, 8'h00);
      wr(8'h70, 8'hff);
      rd(8'h70, 8'h00);
      irq(1'b1);
   endtask
   task automatic t_flags();
      src_a <= 8'h05;
      cyc(2);
      rd(8'h06, 8'h05);
      irq(1'b1);
      wr(8'h04, 8'h08);
      src_a <= 8'h0d;
      cyc(3);
      irq(1'b0);
      rd(8'h06, 8'h0d);
      wr(8'h06, 8'h08);
      #1 chk("sticky_clr_a", 8'h08, clr_a);
      cyc(3);
      irq(1'b1);
      src_a <= 8'h05;
      cyc(2);
      src_a <= 8'h0d;
      cyc(3);
      irq(1'b0);
      soft_rst <= 1'b1;
      cyc(1);
      soft_rst <= 1'b0;
      cyc(2);
      irq(1'b1);
      rd(8'h04, 8'h00);
   endtask
   task automatic t_check();
      for (int i = 0; i < 4; i++) begin
         wr(8'h68 + 8'(2 * i), ref_w[i][7:0]);
         wr(8'h69 + 8'(2 * i), {2'h0, ref_w[i][13:8]});
      end
      wr(8'h05, 8'h06);
      wr(8'h67, 8'he3);
      wr(8'h67, 8'he3);
      cyc(12);
      rd(8'h67, 8'hc1);
      inj <= 1'b1;
      cyc(4);
      inj <= 1'b0;
      cyc(8);
      rd(8'h67, 8'he3);
      rd(8'h70, 8'h01);
      rd(8'h71, 8'h20);
      irq(1'b0);
      cyc(40);
      rd(8'h67, 8'he1);
      rd(8'h70, 8'h00);
      irq(1'b0);
      wr(8'h07, 8'h06);
      #1 chk("sticky_clr_b", 8'h06, clr_b);
      cyc(3);
      irq(1'b1);
      rd(8'h67, 8'hc1);
      wr(8'h67, 8'h83);
      inj <= 1'b1;
      cyc(4);
      inj <= 1'b0;
      cyc(8);
      rd(8'h67, 8'ha0);
      rd(8'h71, 8'h20);
   endtask
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial begin
      #200000;
      error_cnt++;
      close_out();
   end
   initial begin
      rst = 1'b1; ce = 1'b1; soft_rst = 1'b0; reg_wr = 1'b0;
      reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
      src_a = 8'h00; run = 1'b0; inj = 1'b0;
      error_cnt = 0; comparisons = 0;
      ref_w = {14'h3c3c, 14'h0f0f, 14'h2a5c, 14'h1234};
      cyc(2);
      rst <= 1'b0;
      run <= 1'b1;
      t_reset();
      t_flags();
      t_check();
      close_out();
   end
endmodule
`default_nettype wire
